// file: common/flash_cmd_pkg.sv
// constants and types for the flash command logic
// Overview of operation
// - resume acts only while suspended and no write is in progress
// - accepted resume clears suspend at once, sets busy, finishes the held cycle
// - security erase runs only if select rises right after last address byte
// - security erase is self-timed; busy reads 1 until it completes
// - write enable latch clears before a security erase or program finishes
// - once the security lock bit is 1, security erase and program are ignored
// - 4 KB security area at address 000xxx; erase ignores the low 12 bits
// - sixteen pages: bits 11..8 pick the page, bits 7..0 the byte
// - program sends opcode, address, data; select rise starts the timed cycle
// - security read takes address and one dummy byte, then shifts data out
// - read address increments per byte, low 12 bits wrap, until select rises
// - per-block locks apply only when the protect scheme select bit is 0
// - lock and unlock take one block address and finish on select rise
// - lock read returns the block's lock bit in the least significant bit
// - global lock sets every lock bit, global unlock clears them all
// - addresses are 24 bits, 32 bits in four byte address mode
// - accepted suspend sets the suspend flag at once, clears busy in time
package flash_cmd_pkg;
  localparam int CLK_NS = 10;
  localparam int SUSPEND_NS = 100;
  localparam int SUSPEND_CYC = SUSPEND_NS / CLK_NS;
  localparam int SEC_BYTES = 4096;
  localparam int SEC_PAGE_BYTES = 256;
  localparam int LOCK_BLOCKS = 256;
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  localparam logic [7:0] SEC_HI_ZERO = 8'h00;
  localparam logic [3:0] SEC_MID_ZERO = 4'h0;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7a;
  localparam logic [7:0] CMD_SEC_ERASE = 8'h44;
  localparam logic [7:0] CMD_SEC_PROG = 8'h42;
  localparam logic [7:0] CMD_SEC_READ = 8'h48;
  localparam logic [7:0] CMD_LOCK = 8'h36;
  localparam logic [7:0] CMD_UNLOCK = 8'h39;
  localparam logic [7:0] CMD_LOCK_READ = 8'h3d;
  localparam logic [7:0] CMD_GLOBAL_LOCK = 8'h7e;
  localparam logic [7:0] CMD_GLOBAL_UNLOCK = 8'h98;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_OPCODE = 3'b001,
    PH_ADDR   = 3'b010,
    PH_DUMMY  = 3'b011,
    PH_DATA   = 3'b100,
    PH_TAIL   = 3'b101
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE      = 2'b00,
    OP_SEC_ERASE = 2'b01,
    OP_SEC_PROG  = 2'b10,
    OP_ARRAY     = 2'b11
  } op_t;

  // link side to system side, every field but partial is held between events
  typedef struct packed {
    logic [7:0] rx_byte;
    logic       rx_tgl;
    logic       tx_tgl;
    logic       partial;
  } link_t;
endpackage

// file: hdl/flash_link_shift.sv
// serial shifter running on the host's serial clock
module flash_link_shift
  import flash_cmd_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       reset,
  input  wire logic       si,
  input  wire logic [7:0] tx_byte,
  output link_t           link,
  output logic            so,
  output logic            so_oe_n
);
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift;
  } rise_t;

  typedef struct packed {
    logic [6:0] tx_sh;
    logic       so;
    logic       oe_n;
  } fall_t;

  rise_t r_q, r_d;
  link_t k_q, k_d;
  fall_t f_q, f_d;
  logic  ttgl_q, ttgl_d;
  logic  frame_rst;

  // the clock stops between frames, so the frame's own select ends it
  assign frame_rst = reset | cs_n;

  always_comb begin
    r_d = r_q;
    k_d = k_q;
    r_d.bit_cnt = r_q.bit_cnt + 3'h1;
    r_d.shift = {r_q.shift[5:0], si};
    k_d.partial = (r_q.bit_cnt != 3'h7);
    if (r_q.bit_cnt == 3'h7) begin
      // byte held for eight clocks, enough for the system side to take it
      k_d.rx_byte = {r_q.shift, si};
      k_d.rx_tgl = ~k_q.rx_tgl;
    end
    k_d.tx_tgl = ttgl_q;
  end

  always_comb begin
    f_d = f_q;
    ttgl_d = ttgl_q;
    f_d.oe_n = 1'b0;
    if (r_q.bit_cnt == 3'h0) begin
      f_d.so = tx_byte[7];
      f_d.tx_sh = tx_byte[6:0];
      ttgl_d = ~ttgl_q;
    end else begin
      f_d.so = f_q.tx_sh[6];
      f_d.tx_sh = {f_q.tx_sh[5:0], 1'b0};
    end
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      r_q <= rise_t'('0);
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      k_q <= link_t'('0);
    end else begin
      k_q <= k_d;
    end
  end

  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      f_q <= '{tx_sh: 7'h00, so: 1'b0, oe_n: 1'b1};
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
      ttgl_q <= 1'b0;
    end else begin
      ttgl_q <= ttgl_d;
    end
  end

  assign link = k_q;
  assign so = f_q.so;
  assign so_oe_n = f_q.oe_n;
endmodule

// file: hdl/flash_cmd_core.sv
// command interpreter: security area, block locks, suspend and resume
module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter int SECURE_ERASE_CYCLES = 8192,
  parameter int PAGE_PROGRAM_CYCLES = 1024,
  parameter int ARRAY_OP_CYCLES     = 8192
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       four_byte_mode,
  input  wire logic       secreg_lock,
  input  wire logic       protect_scheme_select,
  input  wire logic       block_protect_hit,
  input  wire logic [7:0] query_block,
  input  wire logic       array_op_start,
  output logic            so,
  output logic            so_oe_n,
  output logic            write_in_progress,
  output logic            write_enable_latch,
  output logic            suspend_flags,
  output logic            block_locked
);
  typedef struct packed {
    logic [3:0]                sync1;
    logic [3:0]                sync2;
    logic [3:0]                sync3;
    logic                      cs_late;
    phase_t                    phase;
    logic [7:0]                opcode;
    logic [2:0]                addr_left;
    logic [31:0]               addr;
    logic [8:0]                data_cnt;
    logic                      extra;
    logic [SEC_PAGE_BYTES-1:0] pmask;
    logic [3:0]                prog_page;
    logic [7:0]                tx;
    op_t                       op;
    logic [31:0]               cnt;
    logic [7:0]                scnt;
    logic [12:0]               walk;
    logic                      busy;
    logic                      wr_latch;
    logic                      susp;
    logic                      locked_out;
    logic [LOCK_BLOCKS-1:0]    locks;
  } state_t;

  state_t s, n;
  link_t  link;
  logic [7:0]  mem [SEC_BYTES];
  logic [7:0]  pbuf [SEC_PAGE_BYTES];
  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;
  logic        pb_we;
  logic [7:0]  pb_wa;
  logic [7:0]  pb_wd;
  logic        rx_ev;
  logic        tx_ev;
  logic        cs_fall;
  logic        cs_rise;
  logic        aligned;

  function automatic logic sec_hit(input logic [31:0] a, input logic four);
    sec_hit = (a[23:16] == SEC_HI_ZERO) && (a[15:12] == SEC_MID_ZERO)
              && (!four || a[31:24] == SEC_HI_ZERO);
  endfunction

  function automatic logic [7:0] blk_of(input logic [31:0] a);
    blk_of = a[23:16];
  endfunction

  flash_link_shift u_link (
    .sclk    (sclk),
    .cs_n    (cs_n),
    .reset   (reset),
    .si      (si),
    .tx_byte (s.tx),
    .link    (link),
    .so      (so),
    .so_oe_n (so_oe_n)
  );

  // bit0 select, bit1 receive toggle, bit2 load toggle, bit3 partial byte
  assign rx_ev = s.sync2[1] ^ s.sync3[1];
  assign tx_ev = s.sync2[2] ^ s.sync3[2];
  assign cs_fall = s.sync3[0] & ~s.sync2[0];
  // one stage later than the byte events so a last byte is taken first
  assign cs_rise = ~s.cs_late & s.sync3[0];
  assign aligned = ~s.sync3[3];

  always_comb begin
    logic [31:0] na;
    logic        whole;
    logic        gate;
    na = '0;
    whole = 1'b0;
    gate = 1'b0;
    n = s;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    pb_we = 1'b0;
    pb_wa = '0;
    pb_wd = '0;
    n.sync1 = {link.partial, link.tx_tgl, link.rx_tgl, cs_n};
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    n.cs_late = s.sync3[0];
    n.locked_out = protect_scheme_select ? block_protect_hit
                                         : s.locks[query_block];

    // self-timed cycles
    if (s.busy) begin
      if (s.susp) begin
        n.scnt = s.scnt - 8'h01;
        if (s.scnt == 8'h01) begin
          n.busy = 1'b0;
        end
      end else begin
        n.cnt = s.cnt - 32'h1;
        if (s.walk != 13'h1fff) begin
          n.walk = s.walk + 13'h1;
        end
        case (s.op)
          OP_SEC_ERASE: begin
            if (s.walk < 13'(SEC_BYTES)) begin
              mem_we = 1'b1;
              mem_wa = s.walk[11:0];
              mem_wd = 8'hff;
            end
          end
          OP_SEC_PROG: begin
            if (s.walk < 13'(SEC_PAGE_BYTES) && s.pmask[s.walk[7:0]]) begin
              mem_we = 1'b1;
              mem_wa = {s.prog_page, s.walk[7:0]};
              mem_wd = mem[{s.prog_page, s.walk[7:0]}] & pbuf[s.walk[7:0]];
            end
          end
          default: begin
          end
        endcase
        if (s.cnt == 32'h1) begin
          n.busy = 1'b0;
          n.op = OP_NONE;
        end
      end
    end

    if (array_op_start && !s.busy && !s.susp) begin
      n.op = OP_ARRAY;
      n.cnt = 32'(ARRAY_OP_CYCLES);
      n.busy = 1'b1;
    end

    if (cs_fall) begin
      n.phase = PH_OPCODE;
      n.extra = 1'b0;
      n.data_cnt = '0;
    end

    if (rx_ev) begin
      case (s.phase)
        PH_OPCODE: begin
          n.opcode = link.rx_byte;
          case (link.rx_byte)
            CMD_SEC_ERASE, CMD_SEC_PROG, CMD_SEC_READ,
            CMD_LOCK, CMD_UNLOCK, CMD_LOCK_READ: begin
              n.phase = PH_ADDR;
              n.addr = '0;
              n.addr_left = four_byte_mode ? ADDR_BYTES_4
                                           : ADDR_BYTES_3;
              if (link.rx_byte == CMD_SEC_PROG && !s.busy) begin
                n.pmask = '0;
              end
            end
            default: n.phase = PH_TAIL;
          endcase
        end
        PH_ADDR: begin
          na = {s.addr[23:0], link.rx_byte};
          n.addr = na;
          n.addr_left = s.addr_left - 3'h1;
          // block byte arrives before the low address bytes, so the answer is stable long before use
          if (s.addr_left == ADDR_BYTES_3) begin
            n.tx = {7'h00, s.locks[link.rx_byte]};
          end
          if (s.addr_left == 3'h1) begin
            case (s.opcode)
              CMD_SEC_READ: begin
                n.tx = mem[na[11:0]];
                n.phase = PH_DUMMY;
              end
              CMD_SEC_PROG: n.phase = PH_DATA;
              default: n.phase = PH_TAIL;
            endcase
          end
        end
        PH_DUMMY: n.phase = PH_DATA;
        PH_DATA: begin
          if (s.opcode == CMD_SEC_PROG && !s.busy) begin
            pb_we = 1'b1;
            pb_wa = s.addr[7:0] + s.data_cnt[7:0];
            pb_wd = link.rx_byte;
            n.pmask[pb_wa] = 1'b1;
            if (!s.data_cnt[8]) begin
              n.data_cnt = s.data_cnt + 9'h1;
            end
          end
        end
        PH_TAIL: n.extra = 1'b1;
        default: begin
        end
      endcase
    end

    // each load by the link asks for the following byte
    if (tx_ev && s.phase == PH_DATA && s.opcode == CMD_SEC_READ) begin
      n.addr[11:0] = s.addr[11:0] + 12'h001;
      n.tx = mem[s.addr[11:0] + 12'h001];
    end

    if (cs_rise && s.phase != PH_IDLE) begin
      n.phase = PH_IDLE;
      whole = aligned && !s.extra && s.phase == PH_TAIL;
      gate = s.wr_latch && !s.busy && !s.susp
             && !secreg_lock && sec_hit(s.addr, four_byte_mode);
      case (s.opcode)
        CMD_WRITE_ENABLE: begin
          if (whole) begin
            n.wr_latch = 1'b1;
          end
        end
        CMD_SUSPEND: begin
          if (whole && !s.susp && s.busy && s.op == OP_ARRAY) begin
            n.susp = 1'b1;
            n.scnt = 8'(SUSPEND_CYC);
          end
        end
        CMD_RESUME: begin
          if (whole && s.susp && !s.busy) begin
            n.susp = 1'b0;
            n.busy = 1'b1;
          end
        end
        CMD_SEC_ERASE: begin
          if (whole && gate) begin
            n.op = OP_SEC_ERASE;
            n.cnt = 32'(SECURE_ERASE_CYCLES);
            n.walk = '0;
            n.busy = 1'b1;
            n.wr_latch = 1'b0;
          end
        end
        CMD_SEC_PROG: begin
          if (aligned && s.phase == PH_DATA && s.data_cnt != 9'h0 && gate) begin
            n.op = OP_SEC_PROG;
            n.cnt = 32'(PAGE_PROGRAM_CYCLES);
            n.prog_page = s.addr[11:8];
            n.walk = '0;
            n.busy = 1'b1;
            n.wr_latch = 1'b0;
          end
        end
        CMD_LOCK: begin
          if (whole) begin
            n.locks[blk_of(s.addr)] = 1'b1;
          end
        end
        CMD_UNLOCK: begin
          if (whole) begin
            n.locks[blk_of(s.addr)] = 1'b0;
          end
        end
        CMD_GLOBAL_LOCK: begin
          if (whole) begin
            n.locks = '1;
          end
        end
        CMD_GLOBAL_UNLOCK: begin
          if (whole) begin
            n.locks = '0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= state_t'('0);
    end else begin
      s <= n;
    end
  end

  // storage has no reset; contents are undefined until erased
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pb_we) begin
      pbuf[pb_wa] <= pb_wd;
    end
  end

  assign write_in_progress = s.busy;
  assign write_enable_latch = s.wr_latch;
  assign suspend_flags = s.susp;
  assign block_locked = s.locked_out;
endmodule

// file: testbench/flash_cmd_core_props.sv
// port assertions for the command core
module flash_cmd_core_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic secreg_lock,
  input wire logic protect_scheme_select,
  input wire logic block_protect_hit,
  input wire logic so_oe_n,
  input wire logic write_in_progress,
  input wire logic write_enable_latch,
  input wire logic suspend_flags,
  input wire logic block_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_resume_gate;
    $fell(suspend_flags) |-> !$past(write_in_progress);
  endproperty
  a_resume_gate: assert property (p_resume_gate) else $error("resume while busy");
  property p_resume_busy;
    $fell(suspend_flags) |-> write_in_progress;
  endproperty
  a_resume_busy: assert property (p_resume_busy) else $error("resume left idle");
  property p_suspend_gate;
    $rose(suspend_flags) |-> $past(write_in_progress);
  endproperty
  a_suspend_gate: assert property (p_suspend_gate) else $error("suspend while idle");
  property p_suspend_time;
    $rose(suspend_flags) |-> ##[1:12] !write_in_progress;
  endproperty
  a_suspend_time: assert property (p_suspend_time) else $error("suspend too slow");
  property p_wel_clear;
    $fell(write_enable_latch) |-> ##[0:2] write_in_progress;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch cleared idle");
  // eight cycles of settled lock cover the link crossing delay
  property p_lock_ignore;
    secreg_lock && $past(secreg_lock, 8) |-> !$fell(write_enable_latch);
  endproperty
  a_lock_ignore: assert property (p_lock_ignore) else $error("locked op ran");
  property p_wip_min;
    $rose(write_in_progress) |=> write_in_progress [*8];
  endproperty
  a_wip_min: assert property (p_wip_min) else $error("busy too short");
  property p_scheme;
    protect_scheme_select |=> block_locked == $past(block_protect_hit);
  endproperty
  a_scheme: assert property (p_scheme) else $error("protect bits ignored");
  property p_oe_idle;
    cs_n && $past(cs_n, 3) |-> so_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("so driven idle");
endmodule

bind flash_cmd_core flash_cmd_core_props u_props (
  .sys_clk               (sys_clk),
  .reset                 (reset),
  .cs_n                  (cs_n),
  .secreg_lock           (secreg_lock),
  .protect_scheme_select (protect_scheme_select),
  .block_protect_hit     (block_protect_hit),
  .so_oe_n               (so_oe_n),
  .write_in_progress     (write_in_progress),
  .write_enable_latch    (write_enable_latch),
  .suspend_flags         (suspend_flags),
  .block_locked          (block_locked)
);

// file: testbench/flash_host_model.sv
// host controller model: select, serial clock and data in
module flash_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // odd lead-in keeps the link edges off the system clock grid
  task automatic open_frame();
    #37 cs_n = 1'b0;
    #80;
  endtask
  task automatic shift_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      #80 sclk = 1'b1;
      rx[i] = so_oe_n ? 1'bx : so;
      #80 sclk = 1'b0;
    end
  endtask
  task automatic close_frame();
    #80 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule

// file: testbench/tb_flash_cmd_core.sv
// self-checking bench for the command core
module tb_flash_cmd_core
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk;
  logic       reset;
  logic       four_byte_mode;
  logic       secreg_lock;
  logic       protect_scheme_select;
  logic       block_protect_hit;
  logic [7:0] query_block;
  logic       array_op_start;
  logic       sclk;
  logic       cs_n;
  logic       si;
  logic       so;
  logic       so_oe_n;
  logic       write_in_progress;
  logic       write_enable_latch;
  logic       suspend_flags;
  logic       block_locked;
  logic [7:0] rx;
  int         n_errors;
  int         num_checks;

  flash_host_model u_host (
    .sclk    (sclk),
    .cs_n    (cs_n),
    .si      (si),
    .so      (so),
    .so_oe_n (so_oe_n)
  );
  flash_cmd_core #(
    .SECURE_ERASE_CYCLES (4100),
    .PAGE_PROGRAM_CYCLES (300),
    .ARRAY_OP_CYCLES     (400)
  ) u_dut (
    .sys_clk               (sys_clk),
    .reset                 (reset),
    .sclk                  (sclk),
    .cs_n                  (cs_n),
    .si                    (si),
    .four_byte_mode        (four_byte_mode),
    .secreg_lock           (secreg_lock),
    .protect_scheme_select (protect_scheme_select),
    .block_protect_hit     (block_protect_hit),
    .query_block           (query_block),
    .array_op_start        (array_op_start),
    .so                    (so),
    .so_oe_n               (so_oe_n),
    .write_in_progress     (write_in_progress),
    .write_enable_latch    (write_enable_latch),
    .suspend_flags         (suspend_flags),
    .block_locked          (block_locked)
  );
  always #5 sys_clk = ~sys_clk;

  function automatic logic [7:0] st();
    return {4'h0, write_in_progress, write_enable_latch, suspend_flags, block_locked};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xb(input logic [7:0] b);
    u_host.shift_bits(b, 8, rx);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] adr, input int na);
    u_host.open_frame();
    xb(op);
    for (int i = na - 1; i >= 0; i--) xb(adr[8*i +: 8]);
  endtask
  // statuses settle a few cycles after the select rise crosses over
  task automatic done();
    u_host.close_frame();
    repeat (8) @(posedge sys_clk);
    // look just after the edge, once the launched values have settled
    #1;
  endtask
  task automatic run(input logic [7:0] op, input logic [31:0] adr, input int na);
    cmd(op, adr, na);
    done();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 5000 && write_in_progress !== 1'b0; i++) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_refused();
    run(CMD_SEC_ERASE, 32'h0, 3);
    chk(st(), 8'h00);
    run(CMD_WRITE_ENABLE, 32'h0, 0);
    cmd(CMD_SEC_ERASE, 32'h0, 3);
    u_host.shift_bits(8'hff, 3, rx);
    done();
    chk(st(), 8'h04);
    run(CMD_SEC_ERASE, 32'h011000, 3);
    chk(st(), 8'h04);
    @(posedge sys_clk) secreg_lock <= 1'b1;
    run(CMD_SEC_ERASE, 32'h0, 3);
    chk(st(), 8'h04);
    cmd(CMD_SEC_PROG, 32'h0, 3);
    xb(8'h00);
    done();
    chk(st(), 8'h04);
    @(posedge sys_clk) secreg_lock <= 1'b0;
  endtask
  task automatic t_erase_prog();
    logic [7:0] exp [3] = '{8'h12, 8'h34, 8'hff};
    run(CMD_SEC_ERASE, 32'h000abc, 3);
    chk(st(), 8'h08);
    wait_idle();
    chk(st(), 8'h00);
    run(CMD_WRITE_ENABLE, 32'h0, 0);
    cmd(CMD_SEC_PROG, 32'h000ffe, 3);
    xb(8'h12);
    xb(8'h34);
    done();
    chk(st(), 8'h08);
    wait_idle();
    cmd(CMD_SEC_READ, 32'h000ffe, 3);
    xb(8'h00);
    for (int k = 0; k < 3; k++) begin
      xb(8'h00);
      chk(rx, exp[k]);
    end
    done();
  endtask
  task automatic t_locks();
    @(posedge sys_clk) query_block <= 8'h05;
    run(CMD_LOCK, 32'h050000, 3);
    chk(st(), 8'h01);
    cmd(CMD_LOCK_READ, 32'h050000, 3);
    xb(8'h00);
    done();
    chk(rx, 8'h01);
    run(CMD_UNLOCK, 32'h050000, 3);
    chk(st(), 8'h00);
    run(CMD_GLOBAL_LOCK, 32'h0, 0);
    chk(st(), 8'h01);
    run(CMD_GLOBAL_UNLOCK, 32'h0, 0);
    chk(st(), 8'h00);
    @(posedge sys_clk) four_byte_mode <= 1'b1;
    run(CMD_LOCK, 32'h00050000, 4);
    chk(st(), 8'h01);
    cmd(CMD_SEC_READ, 32'h00000ffe, 4);
    xb(8'h00);
    xb(8'h00);
    done();
    chk(rx, 8'h12);
    @(posedge sys_clk) protect_scheme_select <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(st(), 8'h00);
    @(posedge sys_clk) block_protect_hit <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(st(), 8'h01);
  endtask
  task automatic t_suspend();
    run(CMD_RESUME, 32'h0, 0);
    chk(st(), 8'h01);
    @(posedge sys_clk) array_op_start <= 1'b1;
    @(posedge sys_clk) array_op_start <= 1'b0;
    run(CMD_SUSPEND, 32'h0, 0);
    chk(st(), 8'h03);
    run(CMD_RESUME, 32'h0, 0);
    chk(st(), 8'h09);
    wait_idle();
    chk(st(), 8'h01);
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #500us;
    n_errors++;
    end_of_test();
  end
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    four_byte_mode = 1'b0;
    secreg_lock = 1'b0;
    protect_scheme_select = 1'b0;
    block_protect_hit = 1'b0;
    query_block = 8'h00;
    array_op_start = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({4'h0, write_in_progress, write_enable_latch, suspend_flags, so_oe_n}, 8'h01);
    t_refused();
    t_erase_prog();
    t_locks();
    t_suspend();
    end_of_test();
  end
endmodule
